// [src/scpc_params.svh]
/*
 * Constants for the stop-clock power control block: special cycle
 * encoding, resume timing and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SCPC_PARAMS_SVH
`define SCPC_PARAMS_SVH

// ****************************************************************
// grant acknowledge special cycle
// ****************************************************************
`define SCPC_ACK_ADDR      32'h0000_0010
`define SCPC_ACK_BE        4'hb
`define SCPC_ACK_MIO       1'h0
`define SCPC_ACK_DC        1'h0
`define SCPC_ACK_WR        1'h1

// ****************************************************************
// timing, in core clocks
// ****************************************************************
`define SCPC_RESUME_MIN    10
`define SCPC_RESUME_MAX    20
`define SCPC_RESUME_CYCLES 5'h0c
`define SCPC_RECOG_DELAY   1
`define SCPC_SNOOP_CYCLES  1

// ****************************************************************
// reset values
// ****************************************************************
`define SCPC_RST_CLK_EN    1'h1
`define SCPC_RST_ADDR      32'h0000_0000
`define SCPC_RST_BE        4'hf

`endif

// [src/scpc_pkg.sv]
/*
 * Types shared by the stop-clock power control block.
 * Assumes nothing of its surroundings.
 */
package scpc_pkg;

	typedef enum logic [2:0]
	{
		S_NORMAL,
		S_DRAIN,
		S_ACK_WAIT,
		S_STOP_GRANT,
		S_STOP_CLOCK,
		S_SNOOP,
		S_RESUME
	} scpc_state_t;

	typedef enum logic [2:0]
	{
		EVT_NONE,
		EVT_SOFT_RESTART_IN,
		EVT_PURGE,
		EVT_SMI,
		EVT_NMI,
		EVT_MASKABLE_IRQ,
		EVT_HALT
	} scpc_evt_t;

endpackage

// [src/scpc_sync.sv]
/*
 * Two-stage synchroniser for one asynchronous level.
 * Assumes the destination clock is the core clock.
 */
`timescale 1ns/1ps

module scpc_sync
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic en_in,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_ff;

	// meta_ff feeds only the second stage
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			meta_ff  <= 1'h1;
			sync_out <= 1'h1;
		end
		else if (en_in)
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end

endmodule

// [src/scpc_clk_gate.sv]
/*
 * Glitch-free clock gate: the enable is retimed on the falling edge so
 * that the gated clock can only change while the source clock is low.
 * Assumes en_in is launched from rising-edge logic of the same clock.
 */
`timescale 1ns/1ps

module scpc_clk_gate
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic en_in,
	output logic      gclk_out
);

	logic en_lo_ff;

	always_ff @(negedge clk_in or posedge rst_in)
		if (rst_in)
			en_lo_ff <= 1'h1;
		else
			en_lo_ff <= en_in;

	assign gclk_out = clk_in & en_lo_ff;

endmodule

// [src/scpc_ctrl.sv]
/*
 * Stop-clock power control: halt request sequencing, grant acknowledge
 * cycle, stop grant / stop clock / snoop states, pin states and event
 * priority. Assumes the core reports instruction boundaries, flush and
 * drain status, and that the input clock stop is flagged synchronously.
 */
`timescale 1ns/1ps
`include "scpc_params.svh"

module scpc_ctrl
	import scpc_pkg::*;
(
	input  wire logic        CLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        CLK_EN_IN,
	input  wire logic        CLOCK_HALT_REQUEST_N_IN,
	input  wire logic        SOFT_RESTART_IN,
	input  wire logic        CACHE_PURGE_REQUEST_IN,
	input  wire logic        SYSMGMT_IRQ_IN,
	input  wire logic        NONMASKABLE_IRQ_IN,
	input  wire logic        MASKABLE_IRQ_IN,
	input  wire logic        WRITE_BACK_MODE_IN,
	input  wire logic        INSN_BOUNDARY_IN,
	input  wire logic        AUTO_HALT_IN,
	input  wire logic        FLUSH_BUSY_IN,
	input  wire logic        DRAINED_IN,
	input  wire logic        CYCLE_DONE_NONBURST_IN,
	input  wire logic        CYCLE_DONE_BURST_IN,
	input  wire logic        BUS_IDLE_IN,
	input  wire logic        BUS_TAKEOVER_REQUEST_IN,
	input  wire logic        ADDRESS_FREEZE_REQUEST_IN,
	input  wire logic        BUS_ABORT_REQUEST_IN,
	input  wire logic        EXTERNAL_SNOOP_STROBE_IN,
	input  wire logic        SNOOP_MODIFIED_IN,
	input  wire logic        WRITEBACK_DONE_IN,
	input  wire logic        INPUT_CLK_STOPPED_IN,
	input  wire logic        CORE_DATA_OE_IN,
	input  wire logic        CORE_ATOMIC_IN,
	input  wire logic        CORE_MULTI_ATOMIC_IN,
	output logic             CORE_CLK_OUT,
	output logic             CORE_CLK_EN_OUT,
	output logic             PREFETCH_STOP_OUT,
	output logic             ADDRESS_VALID_STROBE_OUT,
	output logic [31:0]      ADDRESS_OUT,
	output logic [3:0]       BYTE_LANE_ENABLES_OUT,
	output logic             MEMORY_IO_SELECT_OUT,
	output logic             DATA_CODE_SELECT_OUT,
	output logic             WRITE_READ_SELECT_OUT,
	output logic             DATA_OE_OUT,
	output logic             DATA_PARITY_OE_OUT,
	output logic             ADDR_CTRL_OE_OUT,
	output logic             ATOMIC_BUS_OUT,
	output logic             MULTI_CYCLE_ATOMIC_OUT,
	output logic             BUS_TAKEOVER_GRANT_OUT,
	output logic             SNOOP_DIRTY_HIT_OUT,
	output logic             STOP_GRANT_OUT,
	output logic             STOP_CLOCK_OUT,
	output logic             RESUME_OUT,
	output logic             HALT_CYCLE_REQ_OUT,
	output scpc_evt_t        SERVICE_EVT_OUT
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	scpc_state_t state_ff;
	scpc_state_t nxt_state;
	scpc_evt_t   winner;
	logic        halt_n_sync;
	logic        halt_req;
	logic        from_halt_ff;
	logic        recog_ff;
	logic [4:0]  resume_cnt_ff;
	logic        snoop_wb_ff;
	logic        ack_done;
	logic        irq_ok;

	assign halt_req = ~halt_n_sync;
	assign ack_done = CYCLE_DONE_NONBURST_IN | CYCLE_DONE_BURST_IN;
	assign irq_ok   = recog_ff;

	// ****************************************************************
	// halt request synchroniser
	// ****************************************************************
	scpc_sync u_halt_sync
	(
		.clk_in     (CLK_IN),
		.rst_in     (SYS_RST_IN),
		.en_in      (CLK_EN_IN),
		.async_in   (CLOCK_HALT_REQUEST_N_IN),
		.sync_out   (halt_n_sync)
	);

	// ****************************************************************
	// event priority
	// ****************************************************************
	// hard reset needs no slot: it acts on the asynchronous reset
	always_comb
	begin
		winner = EVT_NONE;
		if (WRITE_BACK_MODE_IN)
		begin
			if (CACHE_PURGE_REQUEST_IN)
				winner = EVT_PURGE;
			else if (SOFT_RESTART_IN)
				winner = EVT_SOFT_RESTART_IN;
		end
		else
		begin
			if (SOFT_RESTART_IN)
				winner = EVT_SOFT_RESTART_IN;
			else if (CACHE_PURGE_REQUEST_IN)
				winner = EVT_PURGE;
		end
		if (winner == EVT_NONE)
		begin
			if (SYSMGMT_IRQ_IN && irq_ok)
				winner = EVT_SMI;
			else if (NONMASKABLE_IRQ_IN && irq_ok)
				winner = EVT_NMI;
			else if (MASKABLE_IRQ_IN && irq_ok)
				winner = EVT_MASKABLE_IRQ;
			else if (halt_req)
				winner = EVT_HALT;
		end
	end

	// ****************************************************************
	// sequencing state machine
	// ****************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			S_NORMAL:
				// a held bus cannot drain, so the request waits
				if (INSN_BOUNDARY_IN && winner == EVT_HALT && !BUS_TAKEOVER_GRANT_OUT)
					nxt_state = S_DRAIN;
			S_DRAIN:
				if (!FLUSH_BUSY_IN && DRAINED_IN && BUS_IDLE_IN)
					nxt_state = S_ACK_WAIT;
			S_ACK_WAIT:
				// the request is assumed held until this termination
				if (ack_done && !ADDRESS_VALID_STROBE_OUT)
					nxt_state = S_STOP_GRANT;
			S_STOP_GRANT:
				if (SOFT_RESTART_IN)
					nxt_state = S_NORMAL;
				else if (INPUT_CLK_STOPPED_IN)
					nxt_state = S_STOP_CLOCK;
				else if (EXTERNAL_SNOOP_STROBE_IN)
					nxt_state = S_SNOOP;
				else if (!halt_req)
					nxt_state = S_RESUME;
			S_STOP_CLOCK:
				if (!INPUT_CLK_STOPPED_IN)
					nxt_state = S_STOP_GRANT;
			S_SNOOP:
				if (!snoop_wb_ff || WRITEBACK_DONE_IN)
					nxt_state = S_STOP_GRANT;
			S_RESUME:
				if (resume_cnt_ff == `SCPC_RESUME_CYCLES)
					nxt_state = S_NORMAL;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			state_ff <= S_NORMAL;
		else if (CLK_EN_IN)
			state_ff <= nxt_state;

	// ****************************************************************
	// resume counter and halt origin
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			resume_cnt_ff <= 5'h00;
		else if (CLK_EN_IN)
			resume_cnt_ff <= (state_ff == S_RESUME) ? resume_cnt_ff + 5'h01 : 5'h00;

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			from_halt_ff <= 1'h0;
		else if (CLK_EN_IN && state_ff == S_NORMAL && nxt_state == S_DRAIN)
			from_halt_ff <= AUTO_HALT_IN;

	// ****************************************************************
	// input recognition gate
	// ****************************************************************
	// closed in the low-power states, reopens one clock after release
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			recog_ff <= 1'h1;
		else if (CLK_EN_IN)
			recog_ff <= (state_ff == S_NORMAL || state_ff == S_DRAIN
				|| state_ff == S_ACK_WAIT || state_ff == S_RESUME);

	// ****************************************************************
	// snoop write-back
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			snoop_wb_ff <= 1'h0;
		else if (CLK_EN_IN)
		begin
			if (state_ff == S_STOP_GRANT && nxt_state == S_SNOOP)
				snoop_wb_ff <= SNOOP_MODIFIED_IN;
			else if (WRITEBACK_DONE_IN || state_ff != S_SNOOP)
				snoop_wb_ff <= 1'h0;
		end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			SNOOP_DIRTY_HIT_OUT <= 1'h0;
		else if (CLK_EN_IN)
			SNOOP_DIRTY_HIT_OUT <= (state_ff == S_SNOOP) ? (snoop_wb_ff && !WRITEBACK_DONE_IN)
				: SNOOP_DIRTY_HIT_OUT;

	// ****************************************************************
	// core clock gating
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			CORE_CLK_EN_OUT <= `SCPC_RST_CLK_EN;
		else if (CLK_EN_IN)
			CORE_CLK_EN_OUT <= !(nxt_state == S_STOP_GRANT || nxt_state == S_STOP_CLOCK);

	scpc_clk_gate u_gate
	(
		.clk_in   (CLK_IN),
		.rst_in   (SYS_RST_IN),
		.en_in    (CORE_CLK_EN_OUT),
		.gclk_out (CORE_CLK_OUT)
	);

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			PREFETCH_STOP_OUT <= 1'h0;
		else if (CLK_EN_IN)
			PREFETCH_STOP_OUT <= (nxt_state != S_NORMAL);

	// ****************************************************************
	// grant acknowledge cycle
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			ADDRESS_VALID_STROBE_OUT <= 1'h0;
		else if (CLK_EN_IN)
			ADDRESS_VALID_STROBE_OUT <= (state_ff == S_DRAIN && nxt_state == S_ACK_WAIT);

	// address and definition pins keep their last value in stop grant
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
		begin
			ADDRESS_OUT           <= `SCPC_RST_ADDR;
			BYTE_LANE_ENABLES_OUT <= `SCPC_RST_BE;
			MEMORY_IO_SELECT_OUT  <= 1'h0;
			DATA_CODE_SELECT_OUT  <= 1'h0;
			WRITE_READ_SELECT_OUT <= 1'h0;
		end
		else if (CLK_EN_IN && state_ff == S_DRAIN && nxt_state == S_ACK_WAIT)
		begin
			ADDRESS_OUT           <= `SCPC_ACK_ADDR;
			BYTE_LANE_ENABLES_OUT <= `SCPC_ACK_BE;
			MEMORY_IO_SELECT_OUT  <= `SCPC_ACK_MIO;
			DATA_CODE_SELECT_OUT  <= `SCPC_ACK_DC;
			WRITE_READ_SELECT_OUT <= `SCPC_ACK_WR;
		end

	// ****************************************************************
	// bus takeover and pin states
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			BUS_TAKEOVER_GRANT_OUT <= 1'h0;
		else if (CLK_EN_IN)
		begin
			if (state_ff == S_STOP_GRANT)
				BUS_TAKEOVER_GRANT_OUT <= BUS_TAKEOVER_REQUEST_IN && !INPUT_CLK_STOPPED_IN;
			else if (state_ff == S_NORMAL)
				BUS_TAKEOVER_GRANT_OUT <= BUS_TAKEOVER_REQUEST_IN && BUS_IDLE_IN;
			else if (state_ff != S_STOP_CLOCK)
				BUS_TAKEOVER_GRANT_OUT <= 1'h0;
		end

	// hold-floated group comes back unchanged since its values are held
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			ADDR_CTRL_OE_OUT <= 1'h1;
		else if (CLK_EN_IN)
			ADDR_CTRL_OE_OUT <= !(BUS_TAKEOVER_REQUEST_IN && (state_ff == S_STOP_GRANT
				|| state_ff == S_NORMAL && BUS_IDLE_IN) || ADDRESS_FREEZE_REQUEST_IN
				|| BUS_ABORT_REQUEST_IN);

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
		begin
			DATA_OE_OUT            <= 1'h0;
			DATA_PARITY_OE_OUT     <= 1'h0;
			ATOMIC_BUS_OUT         <= 1'h0;
			MULTI_CYCLE_ATOMIC_OUT <= 1'h0;
		end
		else if (CLK_EN_IN)
		begin
			if (nxt_state == S_NORMAL || nxt_state == S_DRAIN)
			begin
				DATA_OE_OUT            <= CORE_DATA_OE_IN && !BUS_TAKEOVER_REQUEST_IN;
				DATA_PARITY_OE_OUT     <= CORE_DATA_OE_IN && !BUS_TAKEOVER_REQUEST_IN;
				ATOMIC_BUS_OUT         <= CORE_ATOMIC_IN;
				MULTI_CYCLE_ATOMIC_OUT <= CORE_MULTI_ATOMIC_IN && !WRITE_BACK_MODE_IN;
			end
			else
			begin
				DATA_OE_OUT            <= 1'h0;
				DATA_PARITY_OE_OUT     <= 1'h0;
				ATOMIC_BUS_OUT         <= 1'h0;
				MULTI_CYCLE_ATOMIC_OUT <= 1'h0;
			end
		end

	// ****************************************************************
	// status and service outputs
	// ****************************************************************
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
		begin
			STOP_GRANT_OUT     <= 1'h0;
			STOP_CLOCK_OUT     <= 1'h0;
			RESUME_OUT         <= 1'h0;
			HALT_CYCLE_REQ_OUT <= 1'h0;
		end
		else if (CLK_EN_IN)
		begin
			STOP_GRANT_OUT     <= (nxt_state == S_STOP_GRANT);
			STOP_CLOCK_OUT     <= (nxt_state == S_STOP_CLOCK);
			RESUME_OUT         <= (state_ff == S_RESUME && nxt_state == S_NORMAL);
			HALT_CYCLE_REQ_OUT <= (state_ff == S_RESUME && nxt_state == S_NORMAL
				&& from_halt_ff);
		end

	// the halt request itself is never handed on as a serviced event
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			SERVICE_EVT_OUT <= EVT_NONE;
		else if (CLK_EN_IN)
			SERVICE_EVT_OUT <= (state_ff == S_NORMAL && INSN_BOUNDARY_IN
				&& winner != EVT_HALT) ? winner : EVT_NONE;

	// ****************************************************************
	// checks
	// ****************************************************************
	ack_encoding_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		ADDRESS_VALID_STROBE_OUT |-> ADDRESS_OUT == `SCPC_ACK_ADDR
		&& BYTE_LANE_ENABLES_OUT == `SCPC_ACK_BE && !MEMORY_IO_SELECT_OUT
		&& !DATA_CODE_SELECT_OUT && WRITE_READ_SELECT_OUT)
		else $error("bad grant acknowledge encoding");

	grant_blocks_halt_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_NORMAL && BUS_TAKEOVER_GRANT_OUT |=> state_ff != S_DRAIN)
		else $error("halt acted on during bus grant");

	sg_needs_done_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_ACK_WAIT && !ack_done |=> state_ff == S_ACK_WAIT)
		else $error("stop grant without termination");

	sg_pins_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		STOP_GRANT_OUT |-> !DATA_OE_OUT && !DATA_PARITY_OE_OUT && !ATOMIC_BUS_OUT
		&& !MULTI_CYCLE_ATOMIC_OUT && !ADDRESS_VALID_STROBE_OUT && !CORE_CLK_EN_OUT)
		else $error("stop grant pin state wrong");

	resume_window_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_STOP_GRANT && nxt_state == S_RESUME
		|-> ##[`SCPC_RESUME_MIN:`SCPC_RESUME_MAX] state_ff == S_NORMAL)
		else $error("resume outside window");

	halt_sync_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		$fell(CLOCK_HALT_REQUEST_N_IN) ##1 !CLOCK_HALT_REQUEST_N_IN |=> halt_req)
		else $error("halt request not recognised on time");

	no_reentry_ack_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_STOP_CLOCK || state_ff == S_SNOOP |=> !ADDRESS_VALID_STROBE_OUT)
		else $error("acknowledge on re-entry");

	snoop_wake_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_STOP_GRANT && nxt_state == S_SNOOP |=> CORE_CLK_EN_OUT)
		else $error("snoop did not wake core clock");

	soft_restart_in_exit_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_STOP_GRANT && SOFT_RESTART_IN |=> state_ff == S_NORMAL)
		else $error("soft restart did not leave stop grant");

	irq_masked_a:
	assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN || !CLK_EN_IN)
		state_ff == S_STOP_GRANT && $past(state_ff) == S_STOP_GRANT |-> !irq_ok)
		else $error("interrupt recognised in stop grant");

endmodule

// [bench/scpc_chipset_model.sv]
/*
 * Chipset partner: drives the active-low halt request and ends the grant
 * acknowledge cycle, promptly or one clock late, nonburst or burst.
 * Assumes it shares the core clock and hard reset with the device.
 */
`timescale 1ns/1ps

module scpc_chipset_model
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic go_in,
	input  wire logic burst_in,
	input  wire logic slow_in,
	input  wire logic strobe_in,
	output logic      halt_n_out,
	output logic      done_nb_out,
	output logic      done_b_out
);
	logic [2:0] gap_ff;
	logic       acked_ff;
	logic       pend_ff;

	// ************************************************************
	// request and termination
	// ************************************************************
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			halt_n_out  <= 1'h1;
			done_nb_out <= 1'h0;
			done_b_out  <= 1'h0;
			gap_ff      <= 3'h5;
			acked_ff    <= 1'h0;
			pend_ff     <= 1'h0;
		end
		else
		begin
			pend_ff     <= strobe_in;
			// termination only after the strobe cycle, never inside it
			done_nb_out <= (slow_in ? pend_ff : strobe_in) & ~burst_in;
			done_b_out  <= (slow_in ? pend_ff : strobe_in) & burst_in;
			if (done_nb_out | done_b_out)
				acked_ff <= 1'h1;
			if (halt_n_out && gap_ff != 3'h5)
				gap_ff <= gap_ff + 3'h1;
			if (!halt_n_out && !go_in && acked_ff)
			begin
				halt_n_out <= 1'h1;
				gap_ff     <= 3'h0;
				acked_ff   <= 1'h0;
			end
			if (halt_n_out && go_in && gap_ff == 3'h5)
				halt_n_out <= 1'h0;
		end
	end
endmodule

// [bench/scpc_ctrl_tb_top.sv]
/*
 * Self-checking bench for the stop-clock control block.
 * Assumes the chipset model drives the halt request and terminations.
 */
`timescale 1ns/1ps

module scpc_ctrl_tb_top;
	import scpc_pkg::*;

	logic        clk = 0, rst = 1, bnd = 0, flush = 0, sr = 0, purge = 0;
	logic        sysmgmt_irq = 0, nmi = 0, maskable_irq = 0, wb = 0, hold = 0, snoop = 0;
	logic        dirty = 0, wbdone = 0, cstop = 0, go = 0, burst = 0, slow = 0;
	logic        ahalt = 0, drained = 1, afrz = 0, core = 1, gclk, hcr;
	logic        halt_n, dnb, db, strobe, mio, dc, wr, doe, dpoe, aoe, atom;
	logic        matom, grant, snoop_dirty_hit, sg, sc, resume, pstop, cken;
	logic [31:0] addr;
	logic [3:0]  be;
	scpc_evt_t   evt;
	logic [38:0] ackq[$];
	scpc_evt_t   evq[$];
	integer      seed = 32'h291038e9;
	int          n_fail = 0, checks_done = 0, cyc = 0, k, r;

	always #4 clk = ~clk;

	scpc_ctrl i_dut
	(
		.CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1), .CLOCK_HALT_REQUEST_N_IN(halt_n),
		.SOFT_RESTART_IN(sr), .CACHE_PURGE_REQUEST_IN(purge), .SYSMGMT_IRQ_IN(sysmgmt_irq),
		.NONMASKABLE_IRQ_IN(nmi), .MASKABLE_IRQ_IN(maskable_irq), .WRITE_BACK_MODE_IN(wb),
		.INSN_BOUNDARY_IN(bnd), .AUTO_HALT_IN(ahalt), .FLUSH_BUSY_IN(flush),
		.DRAINED_IN(drained), .CYCLE_DONE_NONBURST_IN(dnb), .CYCLE_DONE_BURST_IN(db),
		.BUS_IDLE_IN(1'b1), .BUS_TAKEOVER_REQUEST_IN(hold), .ADDRESS_FREEZE_REQUEST_IN(afrz),
		.BUS_ABORT_REQUEST_IN(1'b0), .EXTERNAL_SNOOP_STROBE_IN(snoop),
		.SNOOP_MODIFIED_IN(dirty), .WRITEBACK_DONE_IN(wbdone), .INPUT_CLK_STOPPED_IN(cstop),
		.CORE_DATA_OE_IN(core), .CORE_ATOMIC_IN(core), .CORE_MULTI_ATOMIC_IN(core),
		.CORE_CLK_OUT(gclk), .CORE_CLK_EN_OUT(cken), .PREFETCH_STOP_OUT(pstop),
		.ADDRESS_VALID_STROBE_OUT(strobe), .ADDRESS_OUT(addr), .BYTE_LANE_ENABLES_OUT(be),
		.MEMORY_IO_SELECT_OUT(mio), .DATA_CODE_SELECT_OUT(dc), .WRITE_READ_SELECT_OUT(wr),
		.DATA_OE_OUT(doe), .DATA_PARITY_OE_OUT(dpoe), .ADDR_CTRL_OE_OUT(aoe),
		.ATOMIC_BUS_OUT(atom), .MULTI_CYCLE_ATOMIC_OUT(matom), .BUS_TAKEOVER_GRANT_OUT(grant),
		.SNOOP_DIRTY_HIT_OUT(snoop_dirty_hit), .STOP_GRANT_OUT(sg), .STOP_CLOCK_OUT(sc),
		.RESUME_OUT(resume), .HALT_CYCLE_REQ_OUT(hcr), .SERVICE_EVT_OUT(evt)
	);

	scpc_chipset_model i_chipset
	(
		.clk_in(clk), .rst_in(rst), .go_in(go), .burst_in(burst), .slow_in(slow),
		.strobe_in(strobe), .halt_n_out(halt_n), .done_nb_out(dnb), .done_b_out(db)
	);

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [38:0] s, input logic [38:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic close_out();
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	function automatic scpc_evt_t win(input logic [5:0] v);
		if (v[4] && !(v[5] && v[3]))
			return EVT_SOFT_RESTART_IN;
		if (v[3])
			return EVT_PURGE;
		if (v[2])
			return EVT_SMI;
		return v[1] ? EVT_NMI : EVT_MASKABLE_IRQ;
	endfunction

	task automatic enter_sg();
		int i;
		r = $random(seed);
		{ahalt, burst, slow} = r[2:0];
		ackq.push_back({32'h0000_0010, 4'hb, 3'h1});
		go = 1;
		bnd = 1;
		flush = 1;
		drained = 0;
		step(8);
		chk(ackq.size(), 1);
		flush = 0;
		// buffers still full: no acknowledge yet
		step(2);
		chk(ackq.size(), 1);
		drained = 1;
		for (i = 0; i < 40 && sg !== 1'b1; i++)
			step(1);
		chk({ackq.size(), sg, pstop, cken}, 39'h6);
		chk({doe, dpoe, atom, matom}, 0);
		// gated clock must stay low through the high phase
		@(posedge clk) #1;
		chk(gclk, 1'b0);
		step(1);
	endtask

	task automatic leave_sg();
		int n;
		go = 0;
		for (n = 0; n < 40 && resume !== 1'b1; n++)
			step(1);
		chk({n >= 10 && n <= 20, hcr}, {1'b1, ahalt});
	endtask

	// ************************************************************
	// result watcher
	// ************************************************************
	always @(negedge clk)
	begin
		if (strobe === 1'b1)
			chk({addr, be, mio, dc, wr}, ackq.size() ? ackq.pop_front() : 0);
		if (!rst && evt !== EVT_NONE)
			chk(evt, evq.size() ? evq.pop_front() : EVT_NONE);
		cyc++;
		// generous ceiling: the whole sequence needs well under 1000 cycles
		if (cyc > 20000)
		begin
			n_fail++;
			close_out();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		step(16);
		chk({cken, aoe, be, sg}, 39'h7e);
		rst = 0;
		step(2);
		for (k = 0; k < 24; k++)
		begin
			r = $random(seed);
			{core, wb, sr, purge, sysmgmt_irq, nmi, maskable_irq} = r[6:0];
			bnd = 1;
			if (r[4:0] != 0)
				evq.push_back(win(r[5:0]));
			step(1);
			chk({doe, dpoe, atom, matom}, {{3{r[6]}}, r[6] & ~r[5]});
			{bnd, sr, purge, sysmgmt_irq, nmi, maskable_irq} = 0;
			step(5);
		end
		hold = 1;
		step(3);
		go = 1;
		bnd = 1;
		step(8);
		chk({grant, pstop, ackq.size()}, {2'h2, 32'h0});
		hold = 0;
		enter_sg();
		hold = 1;
		step(3);
		chk({grant, aoe}, 2'h2);
		hold = 0;
		step(3);
		chk({grant, aoe, addr}, {2'h1, 32'h0000_0010});
		afrz = 1;
		step(2);
		chk({grant, aoe}, 2'h0);
		afrz = 0;
		// interrupt raised in stop grant must wait until after release
		maskable_irq = 1;
		{snoop, dirty} = 2'h3;
		step(1);
		{snoop, dirty} = 0;
		step(4);
		chk({snoop_dirty_hit, sg}, 2'h2);
		wbdone = 1;
		step(1);
		wbdone = 0;
		step(3);
		chk({snoop_dirty_hit, sg, cken}, 3'h2);
		cstop = 1;
		step(3);
		chk({sc, sg}, 2'h2);
		cstop = 0;
		step(3);
		chk({sc, sg}, 2'h1);
		evq.push_back(EVT_MASKABLE_IRQ);
		bnd = 0;
		leave_sg();
		// interrupt held until its one service pulse
		bnd = 1;
		step(1);
		{bnd, maskable_irq} = 0;
		enter_sg();
		bnd = 0;
		sr = 1;
		step(3);
		chk({sg, pstop}, 0);
		sr = 0;
		go = 0;
		step(12);
		chk(ackq.size() + evq.size(), 0);
		close_out();
	end
endmodule
